// >>> core/usbg_dev.sv
`timescale 1ns/1ps
// Overview of operation
// R1: A0..AF then one byte read of status
// R2: Each transaction overwrites endpoint status
// R3: Bit 7 flags event before previous read
// R4: Bit 6 holds last good data toggle
// R5: Bits 4..1 fault code, bit 5 zero
// R6: Bit 0 marks successful transfer
// R7: Codes 0000, 0001 PID, 0010 unknown PID
// R8: Code 0011 unexpected packet type
// R9: Codes 0100 to 1001 CRC, timeout, NAK
// R10: Code 1010 stall handshake returned
// R11: Codes 1011 overflow, 1100 empty ISO
// R12: Codes 1101..1111; bad toggle discards data
// R13: Suspend blocks all register and FIFO writes; the code still passes unlock key writes
// R14: After resume reads wait for unlock
// R15: Host sends B0 then AA37, low first
// R16: Exact key lifts the write protection
// R17: B2 writes, B3 reads 16-bit scratchpad
// R18: Host writes zero into scratch bit 15
// R19: Frame read gives last good SOF number
// R20: One or two frame bytes, lower first
// R21: Frame number undefined after bus reset
// R22: Frame number command is B4
// R23: Eleven-bit frame, upper byte bits 10..8
// R24: Every suspend entry locks; wrong key ignored
module usbg_dev import usbg_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  usbg_port_if.dev_mp LINK,
  input wire logic EV_VALID,
  input wire logic [3:0] EV_EP,
  input wire logic [3:0] EV_CODE,
  input wire logic EV_OK,
  input wire logic EV_TOGGLE,
  input wire logic SOF_VALID,
  input wire logic [10:0] SOF_FRAME,
  input wire logic USB_BUS_RESET,
  input wire logic SUSPEND,
  output logic WRITE_LOCKED,
  output logic READ_LOCKED,
  output logic DATA_DISCARD,
  output logic [15:0] SCRATCH
);
  typedef struct packed {
    logic [EP_COUNT-1:0][7:0] status; // Last result per endpoint
    logic [EP_COUNT-1:0] seen; // Result already read by host
    logic [7:0] opcode; // Command being served
    logic idx; // Data byte index within command
    logic [7:0] rdata; // Byte presented to host
    logic [15:0] scratch; // Firmware scratchpad
    logic [FRAME_W-1:0] frame; // Last good SOF frame number
    logic wlock; // Writes blocked
    logic rlock; // Reads blocked
    logic susp_prev; // Suspend level one cycle ago
    logic discard; // Toggle fault, drop packet data
  } usbg_dev_s;

  usbg_dev_s s_q, s_d;
  logic pair_stb; // Two-byte word assembled
  logic [15:0] pair_word; // Assembled word, low byte first
  logic pair_feed; // Byte belongs to a two-byte write

  // Is the code a result read
  function automatic logic is_result(input logic [7:0] op);
    is_result = (op >= CMD_ERR_FIRST) && (op <= CMD_ERR_LAST); // [R1]
  endfunction

  // Byte the host sees for a command and index
  // A locked read gives zero and leaves the status unread
  function automatic logic [7:0] pick(input logic [7:0] op,
                                      input logic hi,
                                      input usbg_dev_s st);
    pick = 8'h00;
    if (st.rlock) begin
      pick = 8'h00; // Reads withheld until unlock [R14]
    end else if (is_result(op)) begin
      if (!hi) begin
        pick = st.status[op[3:0]]; // Single status byte [R1]
      end
    end else if (op == CMD_SCR_RD) begin
      pick = hi ? st.scratch[15:8] : st.scratch[7:0]; // [R17]
    end else if (op == CMD_FRAME) begin
      // Lower byte first, upper byte zero-filled [R20] [R22] [R23]
      pick = hi ? {5'h00, st.frame[10:8]} : st.frame[7:0];
    end
  endfunction

  // Only unlock and scratch bytes reach the pairer; others drop
  assign pair_feed = LINK.wr_stb &&
                     ((s_q.opcode == CMD_UNLOCK) ||
                      (s_q.opcode == CMD_SCR_WR));

  // Two-byte writes for unlock key and scratchpad
  usbg_pair u_pair (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .start(LINK.cmd_stb),
    .byte_stb(pair_feed),
    .byte_in(LINK.dout),
    .word_stb(pair_stb),
    .word(pair_word)
  );

  // Next state of the whole block
  always_comb begin
    logic [3:0] ep;
    logic ovr;
    ep = EV_EP;
    ovr = 1'b0;
    s_d = s_q;
    s_d.discard = 1'b0;
    s_d.susp_prev = SUSPEND;

    // Command phase: latch code, preload first byte
    if (LINK.cmd_stb) begin
      s_d.opcode = LINK.dout;
      s_d.idx = 1'b0;
      s_d.rdata = pick(LINK.dout, 1'b0, s_q);
    end else if (LINK.rd_stb) begin
      // Host took rdata; present the next byte
      s_d.idx = 1'b1;
      s_d.rdata = pick(s_q.opcode, 1'b1, s_q);
      if (is_result(s_q.opcode) && !s_q.idx && !s_q.rlock) begin
        // Status consumed; overrun was reported with it
        s_d.seen[s_q.opcode[3:0]] = 1'b1; // [R3]
        s_d.status[s_q.opcode[3:0]][ST_OVR_BIT] = 1'b0;
      end
    end

    // Completed two-byte writes
    if (pair_stb) begin
      if (s_q.opcode == CMD_UNLOCK && pair_word == UNLOCK_KEY) begin
        s_d.wlock = 1'b0; // Exact key only [R16] [R24]
        s_d.rlock = 1'b0;
      end
      if (s_q.opcode == CMD_SCR_WR && !s_q.wlock) begin
        s_d.scratch = pair_word; // Stored as written [R17] [R13]
      end
    end

    // Suspend entry locks; wins over an unlock same cycle
    // Edge only: an unlock while the input is still high holds
    // until the next suspend entry; software unlocks after resume
    if (SUSPEND && !s_q.susp_prev) begin
      s_d.wlock = 1'b1; // [R13] [R24]
      s_d.rlock = 1'b1; // [R14]
    end

    // Bus reset: frame is undefined until the next SOF; zero it so
    // software never sees a count from before the reset [R21]
    if (USB_BUS_RESET) begin
      s_d.frame = FRAME_RESET;
    end
    // Only error-free SOFs update the frame number; an SOF in the
    // same cycle as a bus reset is the newer value and wins
    if (SOF_VALID) begin
      s_d.frame = SOF_FRAME; // [R19]
    end

    // Transaction result replaces the old one; set beats read
    if (EV_VALID) begin
      // Set beats a read in the same cycle: judged on the old state
      ovr = !s_q.seen[ep] || s_q.status[ep][ST_OVR_BIT]; // [R3]
      s_d.status[ep][ST_OVR_BIT] = ovr;
      // A failed packet keeps the toggle of the last good one
      if (EV_OK) begin
        s_d.status[ep][ST_TGL_BIT] = EV_TOGGLE; // [R4]
      end
      s_d.status[ep][ST_RSVD_BIT] = 1'b0; // [R5]
      // Fault code passed through as reported [R2] [R5] [R7] [R8]
      s_d.status[ep][ST_CODE_LSB+:4] = EV_CODE; // [R9] [R10] [R11]
      s_d.status[ep][ST_OK_BIT] = EV_OK; // [R6]
      s_d.seen[ep] = 1'b0;
      // Unexpected toggle: packet data must be dropped [R12]
      s_d.discard = (EV_CODE == FLT_TOGGLE);
    end
  end

  // State register; locks clear at power-up
  // Endpoints start as read, so a first result after power-up
  // never shows a false overrun
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q.status <= {EP_COUNT{ST_RESET}};
      s_q.seen <= '1;
      s_q.opcode <= 8'h00;
      s_q.idx <= 1'b0;
      s_q.rdata <= 8'h00;
      s_q.scratch <= SCR_RESET;
      s_q.frame <= FRAME_RESET;
      s_q.wlock <= 1'b0;
      s_q.rlock <= 1'b0;
      s_q.susp_prev <= 1'b0;
      s_q.discard <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, all from flops
  // The lock level is exported so FIFO logic can gate its own
  // write strobes without keeping a second copy
  assign LINK.din = s_q.rdata;
  assign WRITE_LOCKED = s_q.wlock; // Gates FIFO writes elsewhere [R13]
  assign READ_LOCKED = s_q.rlock;
  assign DATA_DISCARD = s_q.discard;
  assign SCRATCH = s_q.scratch;
endmodule

// >>> core/usbg_pkg.sv
package usbg_pkg;
  // Command codes on the parallel port
  localparam logic [7:0] CMD_ERR_FIRST = 8'ha0;
  localparam logic [7:0] CMD_ERR_LAST = 8'haf;
  localparam logic [7:0] CMD_UNLOCK = 8'hb0;
  localparam logic [7:0] CMD_SCR_WR = 8'hb2;
  localparam logic [7:0] CMD_SCR_RD = 8'hb3;
  localparam logic [7:0] CMD_FRAME = 8'hb4;
  // Key that lifts the write protection
  localparam logic [15:0] UNLOCK_KEY = 16'haa37;
  // Endpoint count: control OUT, control IN, endpoints 1 to 14
  localparam int EP_COUNT = 16;
  // Transaction result byte layout
  localparam int ST_OVR_BIT = 7;
  localparam int ST_TGL_BIT = 6;
  localparam int ST_RSVD_BIT = 5;
  localparam int ST_CODE_LSB = 1;
  localparam int ST_OK_BIT = 0;
  localparam logic [7:0] ST_RESET = 8'h00;
  // Scratchpad layout and reset
  localparam int SCR_RSVD_BIT = 15;
  localparam logic [15:0] SCR_RESET = 16'h0000;
  // Frame number width and reset
  localparam int FRAME_W = 11;
  localparam logic [10:0] FRAME_RESET = 11'h000;
  // Host-side APB register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_WDATA = 12'h004;
  localparam logic [11:0] REG_RDATA = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  // Host control and status register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_CNT_LSB = 8;
  localparam int CTRL_DIR_BIT = 10;
  localparam int STAT_BUSY_BIT = 0;

  // Transaction fault codes
  typedef enum logic [3:0] {
    FLT_NONE = 4'h0,
    FLT_PID_ENC = 4'h1,
    FLT_PID_UNK = 4'h2,
    FLT_UNEXP = 4'h3,
    FLT_TOK_CRC = 4'h4,
    FLT_DAT_CRC = 4'h5,
    FLT_TIMEOUT = 4'h6,
    FLT_BABBLE = 4'h7,
    FLT_EOP = 4'h8,
    FLT_NAK = 4'h9,
    FLT_STALL = 4'ha,
    FLT_OVERFLOW = 4'hb,
    FLT_ISO_EMPTY = 4'hc,
    FLT_STUFF = 4'hd,
    FLT_SYNC = 4'he,
    FLT_TOGGLE = 4'hf
  } usbg_fault_e;

  // Host sequencer states
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_CMD = 2'b01,
    H_XFER = 2'b10
  } usbg_hstate_e;
endpackage

// >>> core/usbg_port_if.sv
`timescale 1ns/1ps
// Parallel command/data port, both ends on CORE_CLK
interface usbg_port_if;
  logic cmd_stb; // Command phase, dout holds the code
  logic wr_stb; // Data write phase, dout holds the byte
  logic rd_stb; // Data read phase, host takes din
  logic [7:0] dout; // Host to device byte
  logic [7:0] din; // Device to host byte, from a flop
  modport dev_mp(input cmd_stb, input wr_stb, input rd_stb, input dout,
                 output din);
  modport host_mp(output cmd_stb, output wr_stb, output rd_stb,
                  output dout, input din);
endinterface

// >>> core/usbg_pair.sv
`timescale 1ns/1ps
// Joins two bytes, lower first, into one word
module usbg_pair import usbg_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic byte_stb,
  input wire logic [7:0] byte_in,
  output logic word_stb,
  output logic [15:0] word
);
  typedef struct packed {
    logic [7:0] low; // Held lower byte
    logic have_low; // Lower byte already taken
    logic [15:0] word; // Completed word
    logic stb; // Word completed last cycle
  } usbg_pair_s;

  usbg_pair_s s_q, s_d;

  // Next state: a new command restarts the pairing
  always_comb begin
    s_d = s_q;
    s_d.stb = 1'b0;
    if (start) begin
      s_d.have_low = 1'b0;
    end else if (byte_stb && !s_q.have_low) begin
      s_d.low = byte_in;
      s_d.have_low = 1'b1;
    end else if (byte_stb) begin
      // Odd third byte starts a new pair
      s_d.word = {byte_in, s_q.low};
      s_d.stb = 1'b1;
      s_d.have_low = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign word_stb = s_q.stb;
  assign word = s_q.word;
endmodule

// >>> core/usbg_host.sv
`timescale 1ns/1ps
// Host end: APB orders turned into port sequences
module usbg_host import usbg_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  usbg_port_if.host_mp LINK
);
  typedef struct packed {
    usbg_hstate_e st; // Sequencer state
    logic [7:0] op; // Command code
    logic [1:0] cnt; // Data bytes, 0 to 2
    logic dir; // 1 = read bytes
    logic [15:0] wdata; // Bytes to write
    logic [15:0] rdata; // Bytes read
    logic idx; // Current byte
    logic cmd_stb;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] dout;
    logic [31:0] prdata; // Read data prepared in setup
  } usbg_host_s;

  usbg_host_s s_q, s_d;
  logic acc; // APB access phase
  logic mapped; // Address hits a register
  logic busy;

  assign acc = PSEL && PENABLE;
  assign busy = (s_q.st != H_IDLE);
  assign mapped = (PADDR == REG_CTRL) || (PADDR == REG_WDATA) ||
                  (PADDR == REG_RDATA) || (PADDR == REG_STATUS);

  // Byte sent in data phase; scratch bit 15 forced low
  function automatic logic [7:0] wbyte(input usbg_host_s st,
                                       input logic hi);
    wbyte = st.wdata[7:0]; // Lower byte first [R15]
    if (hi) begin
      wbyte = st.wdata[15:8];
      if (st.op == CMD_SCR_WR) begin
        wbyte[SCR_RSVD_BIT-8] = 1'b0; // [R18]
      end
    end
  endfunction

  // Next state: APB decode and port sequencer
  always_comb begin
    s_d = s_q;
    s_d.cmd_stb = 1'b0;
    s_d.wr_stb = 1'b0;
    s_d.rd_stb = 1'b0;
    // Setup phase: prepare read data so PRDATA comes from a flop
    if (PSEL && !PENABLE) begin
      case (PADDR)
        REG_CTRL: s_d.prdata = {21'h0, s_q.dir, s_q.cnt, s_q.op};
        REG_WDATA: s_d.prdata = {16'h0, s_q.wdata};
        REG_RDATA: s_d.prdata = {16'h0, s_q.rdata};
        REG_STATUS: s_d.prdata = {31'h0, busy};
        default: s_d.prdata = 32'h0;
      endcase
    end
    // Sequencer
    case (s_q.st)
      H_IDLE: begin
        if (acc && PWRITE && PADDR == REG_WDATA) begin
          s_d.wdata = PWDATA[15:0];
        end
        if (acc && PWRITE && PADDR == REG_CTRL) begin
          s_d.op = PWDATA[CTRL_OP_LSB+:8];
          s_d.cnt = PWDATA[CTRL_CNT_LSB+:2];
          s_d.dir = PWDATA[CTRL_DIR_BIT];
          s_d.dout = PWDATA[CTRL_OP_LSB+:8];
          s_d.cmd_stb = 1'b1; // Command phase first [R1] [R15]
          s_d.st = H_CMD;
        end
      end
      H_CMD: begin
        s_d.idx = 1'b0;
        if (s_q.cnt == 2'd0) begin
          s_d.st = H_IDLE;
        end else begin
          s_d.st = H_XFER;
          s_d.rd_stb = s_q.dir;
          s_d.wr_stb = !s_q.dir;
          s_d.dout = wbyte(s_q, 1'b0);
        end
      end
      H_XFER: begin
        if (s_q.rd_stb) begin
          // Lower byte arrives first [R20]
          if (s_q.idx) begin
            s_d.rdata[15:8] = LINK.din;
          end else begin
            s_d.rdata = {8'h00, LINK.din};
          end
        end
        if (s_q.idx || s_q.cnt == 2'd1) begin
          s_d.st = H_IDLE;
        end else begin
          s_d.idx = 1'b1;
          s_d.rd_stb = s_q.dir;
          s_d.wr_stb = !s_q.dir;
          s_d.dout = wbyte(s_q, 1'b1);
        end
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave; unmapped offsets answer with an error
  assign PREADY = acc;
  assign PSLVERR = acc && !mapped;
  assign PRDATA = s_q.prdata;
  assign LINK.cmd_stb = s_q.cmd_stb;
  assign LINK.wr_stb = s_q.wr_stb;
  assign LINK.rd_stb = s_q.rd_stb;
  assign LINK.dout = s_q.dout;
endmodule

// >>> verif/usbg_asserts.sv
`timescale 1ns/1ps
// Watches the parallel port between the host end and the device end
module usbg_asserts import usbg_pkg::*; (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic cmd_stb,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] dout,
  input wire logic [7:0] din
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  // Command phase that selects one endpoint status byte
  logic is_st;
  assign is_st = cmd_stb && dout >= CMD_ERR_FIRST && dout <= CMD_ERR_LAST;

  // One phase per cycle keeps the device decoder unambiguous
  chk_one_strobe: assert property (
    $onehot0({cmd_stb, wr_stb, rd_stb}))
    else $error("more than one port strobe in a cycle");
  // A command is a single pulse
  chk_cmd_pulse: assert property (
    cmd_stb |=> !cmd_stb)
    else $error("command strobe longer than one cycle");
  // Data phases only run on from a command or earlier data
  chk_data_follows: assert property (
    (wr_stb || rd_stb) |-> $past(cmd_stb || wr_stb || rd_stb))
    else $error("data strobe without a command before it");
  // Status command takes exactly one byte read
  chk_status_one: assert property (
    is_st |=> rd_stb ##1 !rd_stb)
    else $error("status command not followed by one read");
  // Reserved status bit reads as zero
  chk_status_rsvd: assert property (
    is_st |=> din[ST_RSVD_BIT] == 1'h0)
    else $error("reserved status bit not zero");
  // Unlock key goes out as two bytes
  chk_unlock_pair: assert property (
    cmd_stb && dout == CMD_UNLOCK |=> wr_stb ##1 wr_stb)
    else $error("unlock command without two data bytes");
  // Scratch top bit always written as zero
  chk_scratch_msb: assert property (
    cmd_stb && dout == CMD_SCR_WR |=> wr_stb ##1 (wr_stb && !dout[7]))
    else $error("scratch high byte bit 7 not zero");
  // Frame upper byte only carries bits 10 to 8
  chk_frame_high: assert property (
    cmd_stb && dout == CMD_FRAME ##1 rd_stb |=> din[7:3] == 5'h00)
    else $error("frame upper byte has unused bits set");
endmodule

// >>> verif/usb_general_command_regs_tb_top.sv
`timescale 1ns/1ps
// Counts one comparison and reports a mismatch at once
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

// Drives the host end over APB and the device end by its event inputs
module usb_general_command_regs_tb_top import usbg_pkg::*; ;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ev_valid = 1'h0;
  logic ev_ok = 1'h0;
  logic ev_tgl = 1'h0;
  logic [3:0] ev_ep = 4'h0;
  logic [3:0] ev_code = 4'h0;
  logic sof_valid = 1'h0;
  logic [10:0] sof_frame = 11'h0;
  logic suspend = 1'h0;
  logic bus_rst = 1'h0;
  logic wr_lock; // Device write protection
  logic rd_lock; // Device read protection
  logic discard; // Bad toggle drop pulse
  logic [15:0] scratch;
  logic [15:0] q;
  logic [31:0] r;
  logic e;
  int miscompares = 0;
  int check_count = 0;

  // 250 MHz core clock
  always #2 clk = ~clk;

  usbg_port_if usbg_port_if_i();
  usbg_host usbg_host_i(.CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINK(usbg_port_if_i));
  // Bus reset is driven; the frame is checked only after a new SOF
  usbg_dev usbg_dev_i(.CORE_CLK(clk), .RESET_N(rst_n),
    .LINK(usbg_port_if_i), .EV_VALID(ev_valid), .EV_EP(ev_ep),
    .EV_CODE(ev_code), .EV_OK(ev_ok), .EV_TOGGLE(ev_tgl),
    .SOF_VALID(sof_valid), .SOF_FRAME(sof_frame), .USB_BUS_RESET(bus_rst),
    .SUSPEND(suspend), .WRITE_LOCKED(wr_lock), .READ_LOCKED(rd_lock),
    .DATA_DISCARD(discard), .SCRATCH(scratch));
  usbg_asserts usbg_asserts_i(.CORE_CLK(clk), .RESET_N(rst_n),
    .cmd_stb(usbg_port_if_i.cmd_stb), .wr_stb(usbg_port_if_i.wr_stb),
    .rd_stb(usbg_port_if_i.rd_stb), .dout(usbg_port_if_i.dout),
    .din(usbg_port_if_i.din));

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A wait that ran out counts as a mismatch
  task automatic fail_out();
    miscompares++;
    test_done();
  endtask

  // One APB transfer; idle cycle first so strobes never change twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic er);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rq = prdata;
    er = pslverr;
    if (n >= 20) fail_out();
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Whole port sequence: data, order, wait for idle, fetch result
  task automatic op(input logic [7:0] c, input logic [1:0] cnt,
                    input logic dir, input logic [15:0] wd,
                    output logic [15:0] rq);
    logic [31:0] t;
    logic er;
    int n;
    apb(1'h1, REG_WDATA, {16'h0, wd}, t, er);
    apb(1'h1, REG_CTRL, {21'h0, dir, cnt, c}, t, er);
    n = 0;
    t = 32'h1;
    while (t[STAT_BUSY_BIT] !== 1'h0 && n < 20) begin
      apb(1'h0, REG_STATUS, 32'h0, t, er);
      n++;
    end
    if (n >= 20) fail_out();
    apb(1'h0, REG_RDATA, 32'h0, t, er);
    rq = t[15:0];
  endtask

  // One transaction result; drop pulse follows only a bad toggle
  task automatic ev(input logic [3:0] ep, input logic [3:0] code,
                    input logic ok, input logic tg);
    @(posedge clk);
    ev_valid <= 1'h1;
    ev_ep <= ep;
    ev_code <= code;
    ev_ok <= ok;
    ev_tgl <= tg;
    @(posedge clk);
    ev_valid <= 1'h0;
    #1;
    `CHK("discard", code == 4'hf, discard)
  endtask

  // Status byte read of one endpoint
  task automatic st(input logic [3:0] ep, input logic [7:0] x);
    logic [15:0] v;
    op(CMD_ERR_FIRST | {4'h0, ep}, 2'h1, 1'h1, 16'h0, v);
    `CHK("status", {8'h0, x}, v)
  endtask

  // Error-free start of frame
  task automatic sof(input logic [10:0] f);
    @(posedge clk);
    sof_valid <= 1'h1;
    sof_frame <= f;
    @(posedge clk);
    sof_valid <= 1'h0;
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fail_out();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    `CHK("scratch rst", SCR_RESET, scratch)
    `CHK("wlock rst", 1'h0, wr_lock)
    op(CMD_SCR_RD, 2'h2, 1'h1, 16'h0, q);
    `CHK("scratch rd", SCR_RESET, q)
    op(CMD_SCR_WR, 2'h2, 1'h0, 16'hffff, q);
    `CHK("scratch msb", 16'h7fff, scratch)
    op(CMD_SCR_WR, 2'h2, 1'h0, 16'h1234, q);
    op(CMD_SCR_RD, 2'h2, 1'h1, 16'h0, q);
    `CHK("scratch rd", 16'h1234, q)
    // Every fault code once, each on its own endpoint
    for (int i = 0; i < EP_COUNT; i++) begin
      ev(4'(i), 4'(i), i == 0, i == 0);
      st(4'(i), {1'h0, i == 0, 1'h0, 4'(i), i == 0});
    end
    // Second result before the first was read
    ev(4'h3, 4'h6, 1'h0, 1'h0);
    ev(4'h3, 4'h0, 1'h1, 1'h1);
    st(4'h3, 8'hc1);
    ev(4'h3, 4'h9, 1'h0, 1'h0);
    st(4'h3, 8'h52);
    sof(11'h2ff);
    sof(11'h5a3);
    op(CMD_FRAME, 2'h2, 1'h1, 16'h0, q);
    `CHK("frame", 16'h05a3, q)
    op(CMD_FRAME, 2'h1, 1'h1, 16'h0, q);
    `CHK("frame one", 16'h00a3, q)
    // Bus reset, then a fresh SOF: only the new number counts
    @(posedge clk);
    bus_rst <= 1'h1;
    @(posedge clk);
    bus_rst <= 1'h0;
    sof(11'h123);
    op(CMD_FRAME, 2'h2, 1'h1, 16'h0, q);
    `CHK("frame new", 16'h0123, q)
    // Suspend locks, resume keeps the lock until the exact key
    @(posedge clk);
    suspend <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("wlock", 1'h1, wr_lock)
    `CHK("rlock", 1'h1, rd_lock)
    op(CMD_SCR_WR, 2'h2, 1'h0, 16'h0f0f, q);
    `CHK("scratch held", 16'h1234, scratch)
    @(posedge clk);
    suspend <= 1'h0;
    op(CMD_SCR_RD, 2'h2, 1'h1, 16'h0, q);
    `CHK("locked rd", 16'h0000, q)
    op(CMD_UNLOCK, 2'h2, 1'h0, 16'haa38, q);
    `CHK("wrong key", 1'h1, wr_lock)
    op(CMD_UNLOCK, 2'h2, 1'h0, UNLOCK_KEY, q);
    `CHK("unlock w", 1'h0, wr_lock)
    `CHK("unlock r", 1'h0, rd_lock)
    op(CMD_SCR_RD, 2'h2, 1'h1, 16'h0, q);
    `CHK("scratch kept", 16'h1234, q)
    apb(1'h0, 12'h010, 32'h0, r, e);
    `CHK("unmapped err", 1'h1, e)
    `CHK("unmapped rd", 32'h0, r)
    test_done();
  end
endmodule
